// File: design/gp_port_pkg.sv
// Contract
// - after init: pins 16-23 in, 24-31 out
// - whole read returns eight inputs at once
// - whole write sets eight outputs at once
// - single read: index 0-7, returns level
// - single write: index 0-7 drives level
// - single write leaves other outputs unchanged
// - finalize restores reset directions and data
// - tick variant refreshes sampled input each tick
// - tick variant applies requested output each tick with no software write or finish
// - 64 shared pins, usable when bus idle
package gp_port_pkg;
	localparam int PIN_COUNT = 64;
	localparam int IN_BASE = 16;
	localparam int OUT_BASE = 24;
	localparam int GROUP_W = 8;
	localparam logic [63:0] DIR_RESET = 64'h0000_0000_0000_0000;
	localparam logic [63:0] DATA_RESET = 64'h0000_0000_0000_0000;
	localparam logic [63:0] DIR_INIT = 64'h0000_0000_FF00_0000;
	localparam real CLK_MHZ = 40.0;
	localparam real TICK_PERIOD_MS = 1.0;
	localparam int TICK_CYCLES = int'(TICK_PERIOD_MS * CLK_MHZ * 1000.0);

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_INIT = 3'h1,
		OP_RD_ALL = 3'h2,
		OP_WR_ALL = 3'h3,
		OP_RD_ONE = 3'h4,
		OP_WR_ONE = 3'h5,
		OP_FINISH = 3'h6
	} op_t;

	typedef struct packed {
		op_t op;
		logic [2:0] index;
		logic [7:0] data;
	} gp_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} gp_rsp_t;
endpackage

// File: design/general_purpose_io_port.sv
`timescale 1ns/1ps
`default_nettype none
module general_purpose_io_port
	import gp_port_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire gp_req_t req,
	input wire logic bus_owns_pins,
	input wire logic tick_read_en,
	input wire logic tick_write_en,
	input wire logic [7:0] tick_write_data,
	input wire logic [63:0] gp_data_pin_in,
	output logic [63:0] gp_data_pin_out,
	output logic [63:0] gp_data_pin_oe,
	output var gp_rsp_t rsp,
	output logic [7:0] tick_sample,
	output logic tick_pulse
);
	logic [63:0] sync1_r;
	logic [63:0] sync2_r;
	logic [63:0] dir_r;
	logic [63:0] data_r;
	logic [63:0] dir_nxt;
	logic [63:0] data_nxt;
	logic [31:0] tick_cnt_r;
	logic tick_r;
	gp_rsp_t rsp_nxt;

	// pick one bit of a byte
	function automatic logic pick_bit(input logic [7:0] v, input logic [2:0] i);
		pick_bit = v[i];
	endfunction

	// input group and current output group views
	wire logic [7:0] in_grp = sync2_r[IN_BASE +: GROUP_W];
	wire logic [7:0] out_grp = data_r[OUT_BASE +: GROUP_W];
	wire logic [7:0] one_mask = 8'h01 << req.index;
	wire logic [7:0] wr_one_grp = (out_grp & ~one_mask) | ({8{req.data[0]}} & one_mask);
	wire logic tick_hit = (tick_cnt_r == 32'(TICK_DIV - 1));

	// next direction and data from request or tick
	always_comb begin
		dir_nxt = dir_r;
		data_nxt = data_r;
		rsp_nxt = '0;
		case (req.op)
			OP_INIT: begin
				dir_nxt = DIR_INIT;
			end
			OP_RD_ALL: begin
				rsp_nxt = '{valid: 1'b1, data: in_grp};
			end
			OP_WR_ALL: begin
				data_nxt[OUT_BASE +: GROUP_W] = req.data;
			end
			OP_RD_ONE: begin
				rsp_nxt = '{valid: 1'b1, data: {7'h00, pick_bit(in_grp, req.index)}};
			end
			OP_WR_ONE: begin
				data_nxt[OUT_BASE +: GROUP_W] = wr_one_grp;
			end
			OP_FINISH: begin
				dir_nxt = DIR_RESET;
				data_nxt = DATA_RESET;
			end
			default: begin
			end
		endcase
		// tick variant only when no software write this cycle
		if (tick_hit && tick_write_en && req.op != OP_WR_ALL && req.op != OP_WR_ONE && req.op != OP_FINISH) begin
			data_nxt[OUT_BASE +: GROUP_W] = tick_write_data;
		end
	end

	// two-stage input synchroniser
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= gp_data_pin_in;
			sync2_r <= sync1_r;
		end
	end

	// periodic tick divider
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_cnt_r <= tick_hit ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
			tick_r <= tick_hit;
		end
	end

	// tick-driven input sample
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_sample <= '0;
		end else if (tick_hit && tick_read_en) begin
			tick_sample <= in_grp;
		end
	end

	// port state and response
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dir_r <= DIR_RESET;
			data_r <= DATA_RESET;
			rsp <= '0;
		end else begin
			dir_r <= dir_nxt;
			data_r <= data_nxt;
			rsp <= rsp_nxt;
		end
	end

	// pin drivers, released while the bus owns the lines
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gp_data_pin_out <= '0;
			gp_data_pin_oe <= '0;
		end else begin
			gp_data_pin_out <= data_nxt;
			gp_data_pin_oe <= bus_owns_pins ? 64'h0000_0000_0000_0000 : dir_nxt;
		end
	end

	assign tick_pulse = tick_r;
endmodule
`default_nettype wire

// File: verif/gp_pins.sv
`timescale 1ns/1ps
`default_nettype none
// far pins: lines not in the input group toggle
module gp_pins(input wire logic clk,input wire logic [7:0] lvl,output logic [63:0] pin_in);
	logic t=0;
	always @(posedge clk) t<=~t;
	assign pin_in={{40{t}},lvl,{16{~t}}};
endmodule
`default_nettype wire

// File: verif/gp_props.sv
`timescale 1ns/1ps
`default_nettype none
module gp_props import gp_port_pkg::*; (input wire logic clk,rst,bus_owns_pins,input wire gp_req_t req,
input wire gp_rsp_t rsp,input wire logic [63:0] gp_data_pin_in,gp_data_pin_out,gp_data_pin_oe);
	// short views of the ports
	wire [2:0] c=req.op;
	wire [7:0] o=gp_data_pin_out[31:24];
	default clocking @(posedge clk);endclocking
	default disable iff(rst);
	sequence calm_s;$stable(gp_data_pin_in[23:16])[*3]##0 c==OP_RD_ALL;endsequence
	init_dir_a:assert property(c==OP_INIT&&!bus_owns_pins|=>gp_data_pin_oe[31:16]==16'hff00)else $error("dir");
	rd_all_a:assert property(calm_s|=>rsp.data==$past(gp_data_pin_in[23:16]))else $error("rd");
	wr_all_a:assert property(c==OP_WR_ALL|=>o==$past(req.data))else $error("wr");
	wr_one_a:assert property(c==OP_WR_ONE|=>o==($past(o)&~(1<<$past(req.index))|$past(req.data[0])<<$past(req.index)))
		else $error("wr1");
	finish_clear_a:assert property(c==OP_FINISH|=>gp_data_pin_oe==0&&gp_data_pin_out==0)else $error("fin");
	rd_one_a:assert property(c==OP_RD_ONE|=>rsp.valid&&rsp.data[7:1]==7'h00)else $error("rd1");
	bus_release_a:assert property(bus_owns_pins|=>gp_data_pin_oe==64'h0000_0000_0000_0000)else $error("bus");
endmodule
bind general_purpose_io_port gp_props chk(.clk,.rst,.bus_owns_pins,.req,.rsp,.gp_data_pin_in,.gp_data_pin_out,.gp_data_pin_oe);
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin total_checks++;if((a)!==(b))begin errors++;$display("CHECK FAILED %0t value mismatch",$time);end end
module testbench;
	import gp_port_pkg::*;
	logic clk,rst,t,b,tp;
	logic [63:0] e;
	int n=0;
	logic [7:0] l,r,s;
	logic [63:0] p,o;
	int errors,total_checks,seed=7727;
	gp_req_t req;
	gp_rsp_t rsp;
	logic [7:0] q[$];
	general_purpose_io_port #(.TICK_DIV(8)) dut(.clk,.rst,.req,.bus_owns_pins(b),.tick_read_en(t),.tick_write_en(t),
		.tick_write_data(r),.gp_data_pin_in(p),.gp_data_pin_out(o),.gp_data_pin_oe(e),.rsp,.tick_sample(s),.tick_pulse(tp));
	// count tick pulses
	always @(posedge clk) if(tp===1'b1) n++;
	gp_pins pm(.clk,.lvl(l),.pin_in(p));
	initial begin
		clk=0;
		forever #12.5 clk=~clk;
	end
	// each answer against oldest note
	always @(negedge clk) if(rsp.valid===1)`CHK(rsp.data,q.pop_front())
	task op(op_t c,logic [2:0] i);
		@(negedge clk) req='{c,i,r};
		@(negedge clk) req='0;
	endtask
	// reads, writes, tick and finish
	initial begin
		rst=1;
		{t,b,l,r,req}='0;
		repeat(12) @(negedge clk);
		rst=0;
		op(OP_INIT,0);
		repeat(8) begin
			l=$random(seed);
			r=$random(seed);
			repeat(3) @(negedge clk);
			q.push_back(l);
			op(OP_RD_ALL,0);
			q.push_back(l[r[2:0]]);
			op(OP_RD_ONE,r[2:0]);
			op(OP_WR_ALL,0);
			op(OP_WR_ONE,r[5:3]);
		end
		`CHK(e[31:16],16'hff00)
		t=1;
		b=1;
		repeat(20) @(negedge clk);
		`CHK(s,l)
		`CHK(o[31:24],r)
		`CHK(e,64'h0000_0000_0000_0000)
		`CHK(n>0,1'b1)
		t=0;
		b=0;
		op(OP_FINISH,0);
		@(negedge clk);
		summarize();
	end
	initial begin
		#20us;
		errors++;
		summarize();
	end
	task summarize;
		$display("%0d of %0d failed",errors,total_checks);
		if(errors==0&&total_checks>0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
endmodule
`default_nettype wire
